// file: verilog/hpci_pkg.sv
// Package of constants and types for the host packet command interpreter
`default_nettype none
package hpci_pkg;
  localparam logic [7:0] TYPE_REQUEST = 8'h52;
  localparam logic [7:0] TYPE_CONFIRM = 8'h43;
  localparam logic [7:0] TYPE_INDICATE = 8'h69;
  localparam logic [7:0] OP_BEGIN_READING = 8'h00;
  localparam logic [7:0] OP_CANCEL_READING = 8'h01;
  localparam logic [7:0] OP_BEGIN_CALIBRATE = 8'h02;
  localparam logic [7:0] OP_SAMPLE_PRESENT = 8'h03;
  localparam logic [7:0] OP_READING_DONE = 8'h04;
  localparam logic [7:0] OP_CALIBRATE_DONE = 8'h05;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_BUSY = 8'h01;
  localparam logic [7:0] STATUS_BAD_OP = 8'h02;
  localparam logic [7:0] CONFIRM_LEN = 8'h01;
  localparam logic [7:0] SEQ_LEN = 8'h02;
  localparam logic [7:0] DATA_LEN = 8'h04;
  localparam logic [15:0] SEQ_RESET = 16'h0000;
  localparam int CLK_HZ = 100000000;
  localparam int BAUD = 115200;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int FRAME_BITS = 10;
  localparam int CNT_W = 10;
  // Event kinds presented to the tx engine
  localparam logic [1:0] EV_SAMPLE = 2'd0;
  localparam logic [1:0] EV_READING = 2'd1;
  localparam logic [1:0] EV_CALIB = 2'd2;
endpackage : hpci_pkg
`default_nettype wire

// file: verilog/hpci_byte_if.sv
// Byte handshake carrier between the interpreter and its serial engine
`default_nettype none
interface hpci_byte_if;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic rx_valid;
  logic [7:0] rx_data;
  modport core (output tx_valid, output tx_data, input tx_ready, input rx_valid,
    input rx_data);
  modport phy (input tx_valid, input tx_data, output tx_ready, output rx_valid,
    output rx_data);
endinterface : hpci_byte_if
`default_nettype wire

// file: verilog/hpci_uart.sv
// 8N1 serial byte engine, both directions
`default_nettype none
module hpci_uart (
  input wire logic i_ref_clk, // System clock
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_rxd, // Serial line in
  output logic o_txd, // Serial line out
  hpci_byte_if.phy bus // Byte handshake
);
  typedef struct packed {
    logic [2:0] sync;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_v;
    logic [7:0] rx_byte;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
  } hpci_uart_s;
  localparam logic [15:0] BITC = 16'(hpci_pkg::BIT_CYC - 1);
  localparam logic [15:0] HALFC = 16'(hpci_pkg::HALF_CYC - 1);
  localparam logic [3:0] LASTB = 4'(hpci_pkg::FRAME_BITS - 1);
  hpci_uart_s r_q, r_d;
  logic rx_lvl;
  // Level is the third stage; a start counts once second and third stages agree
  assign rx_lvl = r_q.sync[2];
  assign o_txd = r_q.tx_busy ? r_q.tx_sh[0] : 1'b1;
  assign bus.tx_ready = !r_q.tx_busy;
  assign bus.rx_valid = r_q.rx_v;
  assign bus.rx_data = r_q.rx_byte;
  // Both directions of the 8N1 frame, no parity, no flow control
  always_comb begin
    r_d = r_q;
    r_d.rx_v = 1'b0;
    r_d.sync = {r_q.sync[1:0], i_rxd};
    if (!r_q.rx_busy) begin
      if (r_q.sync[2] == r_q.sync[1] && !rx_lvl) begin
        r_d.rx_busy = 1'b1;
        r_d.rx_cnt = HALFC;
        r_d.rx_bit = 4'h0;
      end
    end else if (r_q.rx_cnt != 16'h0000) begin
      r_d.rx_cnt = r_q.rx_cnt - 16'h0001;
    end else begin
      r_d.rx_cnt = BITC;
      r_d.rx_bit = r_q.rx_bit + 4'h1;
      if (r_q.rx_bit == 4'h0) begin
        // False start glitch drops back to idle
        if (rx_lvl) r_d.rx_busy = 1'b0;
      end else if (r_q.rx_bit == LASTB) begin
        r_d.rx_busy = 1'b0;
        // Framing error: missing stop bit discards the byte
        if (rx_lvl) begin
          r_d.rx_v = 1'b1;
          r_d.rx_byte = r_q.rx_sh;
        end
      end else begin
        r_d.rx_sh = {rx_lvl, r_q.rx_sh[7:1]};
      end
    end
    if (!r_q.tx_busy) begin
      if (bus.tx_valid) begin
        r_d.tx_busy = 1'b1;
        r_d.tx_sh = {1'b1, bus.tx_data, 1'b0};
        r_d.tx_cnt = BITC;
        r_d.tx_bit = 4'h0;
      end
    end else if (r_q.tx_cnt != 16'h0000) begin
      r_d.tx_cnt = r_q.tx_cnt - 16'h0001;
    end else begin
      r_d.tx_cnt = BITC;
      r_d.tx_sh = {1'b1, r_q.tx_sh[9:1]};
      r_d.tx_bit = r_q.tx_bit + 4'h1;
      if (r_q.tx_bit == LASTB) r_d.tx_busy = 1'b0;
    end
  end
  // State register with enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      r_q <= '0;
      r_q.sync <= 3'h7;
      r_q.tx_sh <= 10'h3ff;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end
endmodule : hpci_uart
`default_nettype wire

// file: verilog/hpci_top.sv
// Packet command interpreter for the glucose instrument
`default_nettype none
module hpci_top (
  input wire logic i_ref_clk, // System clock, 100 MHz
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_rxd, // Serial line from host
  output logic o_txd, // Serial line to host
  input wire logic i_sample_present, // Pulse: blood on strip
  input wire logic i_reading_done, // Pulse: reading finished
  input wire logic i_calibrate_done, // Pulse: calibration finished
  input wire logic [15:0] i_result, // Result for done events
  input wire logic i_busy, // Instrument cannot take a start
  output logic o_begin_reading, // Pulse: start measurement
  output logic o_cancel_reading, // Pulse: abort
  output logic o_begin_calibrate, // Pulse: start calibration
  output logic o_session_active // Level: streaming enabled
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_OPC = 6'b000010,
    ST_CFM = 6'b000100,
    ST_IND = 6'b001000,
    ST_WAIT = 6'b010000,
    ST_DONE = 6'b100000
  } hpci_state_e;
  typedef struct packed {
    hpci_state_e st;
    logic active;
    logic [7:0] opc;
    logic [7:0] status;
    logic cfm_pend;
    logic in_cfm; // Packet on the wire is a confirmation
    logic [2:0] pend_ev;
    logic [1:0] cur_ev;
    logic [15:0] cur_res;
    logic [15:0] seq;
    logic [2:0] idx;
    logic [7:0] txb;
    logic txv;
    logic go_read;
    logic go_cancel;
    logic go_cal;
    logic [15:0] res_hold;
  } hpci_state_s;
  hpci_state_s r_q, r_d;
  hpci_byte_if link ();
  logic [2:0] ev_in;
  logic [7:0] ind_len;
  assign ev_in = {i_calibrate_done, i_reading_done, i_sample_present};
  // Serial engine for the virtual serial port byte stream
  hpci_uart u_uart (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_rxd(i_rxd),
    .o_txd(o_txd),
    .bus(link.phy)
  );
  assign link.tx_valid = r_q.txv;
  assign link.tx_data = r_q.txb;
  assign o_begin_reading = r_q.go_read;
  assign o_cancel_reading = r_q.go_cancel;
  assign o_begin_calibrate = r_q.go_cal;
  assign o_session_active = r_q.active;
  // Sample present carries only the sequence number, done events add a result
  assign ind_len = (r_q.cur_ev == hpci_pkg::EV_SAMPLE) ? hpci_pkg::SEQ_LEN
                                                        : hpci_pkg::DATA_LEN;
  // Receive parse, command decode, and packet serialiser
  always_comb begin
    r_d = r_q;
    r_d.go_read = 1'b0;
    r_d.go_cancel = 1'b0;
    r_d.go_cal = 1'b0;
    // Events latch while streaming; set wins over the clear at send time
    for (int k = 0; k < 3; k++) begin
      if (ev_in[k] && r_q.active) r_d.pend_ev[k] = 1'b1;
    end
    if (i_reading_done || i_calibrate_done) r_d.res_hold = i_result;
    // Receive side: type byte then opcode, no length byte follows a request
    if (link.rx_valid) begin
      if (r_q.cfm_pend) begin
        // A new command while one awaits confirmation is dropped
        r_d.cfm_pend = r_q.cfm_pend;
      end else if (r_q.opc[0] == 1'b0 && r_q.status == 8'hff) begin
        // Awaiting opcode of a request
        r_d.status = 8'h00;
        r_d.opc = link.rx_data;
        r_d.cfm_pend = 1'b1;
        case (link.rx_data)
          hpci_pkg::OP_BEGIN_READING, hpci_pkg::OP_BEGIN_CALIBRATE: begin
            if (i_busy || r_q.active) begin
              r_d.status = hpci_pkg::STATUS_BUSY;
            end else begin
              r_d.status = hpci_pkg::STATUS_OK;
              r_d.active = 1'b1;
              r_d.seq = hpci_pkg::SEQ_RESET;
              r_d.go_read = (link.rx_data == hpci_pkg::OP_BEGIN_READING);
              r_d.go_cal = (link.rx_data == hpci_pkg::OP_BEGIN_CALIBRATE);
            end
          end
          hpci_pkg::OP_CANCEL_READING: begin
            // Stop drops streaming at once and queued events
            r_d.status = hpci_pkg::STATUS_OK;
            r_d.active = 1'b0;
            r_d.pend_ev = 3'h0;
            r_d.go_cancel = 1'b1;
          end
          default: begin
            // Other families' codes are not decoded in this build
            r_d.status = hpci_pkg::STATUS_BAD_OP;
          end
        endcase
      end else if (link.rx_data == hpci_pkg::TYPE_REQUEST) begin
        r_d.status = 8'hff;
        r_d.opc = 8'h00;
      end else begin
        // Bytes other than the request type are thrown away
        r_d.status = 8'h00;
        r_d.opc = 8'h01;
      end
    end
    // Transmit serialiser
    r_d.txv = 1'b0;
    case (r_q.st)
      ST_IDLE: begin
        r_d.idx = 3'h0;
        if (r_q.cfm_pend) begin
          r_d.st = ST_CFM;
          r_d.in_cfm = 1'b1;
        end else if (r_q.active && r_q.pend_ev != 3'h0) begin
          r_d.st = ST_IND;
          r_d.in_cfm = 1'b0;
          if (r_q.pend_ev[0]) begin
            r_d.cur_ev = hpci_pkg::EV_SAMPLE;
            r_d.pend_ev[0] = ev_in[0];
          end else if (r_q.pend_ev[1]) begin
            r_d.cur_ev = hpci_pkg::EV_READING;
            r_d.pend_ev[1] = ev_in[1];
          end else begin
            r_d.cur_ev = hpci_pkg::EV_CALIB;
            r_d.pend_ev[2] = ev_in[2];
          end
          r_d.cur_res = r_q.res_hold;
        end
      end
      ST_CFM: begin
        // Type, echoed opcode, length one, status
        r_d.txv = 1'b1;
        case (r_q.idx)
          3'h0: r_d.txb = hpci_pkg::TYPE_CONFIRM;
          3'h1: r_d.txb = r_q.opc;
          3'h2: r_d.txb = hpci_pkg::CONFIRM_LEN;
          default: r_d.txb = r_q.status;
        endcase
        r_d.st = ST_WAIT;
      end
      ST_IND: begin
        r_d.txv = 1'b1;
        case (r_q.idx)
          3'h0: r_d.txb = hpci_pkg::TYPE_INDICATE;
          3'h1: r_d.txb = (r_q.cur_ev == hpci_pkg::EV_SAMPLE) ? hpci_pkg::OP_SAMPLE_PRESENT :
                          (r_q.cur_ev == hpci_pkg::EV_READING) ? hpci_pkg::OP_READING_DONE :
                          hpci_pkg::OP_CALIBRATE_DONE;
          3'h2: r_d.txb = ind_len;
          3'h3: r_d.txb = r_q.seq[15:8];
          3'h4: r_d.txb = r_q.seq[7:0];
          3'h5: r_d.txb = r_q.cur_res[15:8];
          default: r_d.txb = r_q.cur_res[7:0];
        endcase
        r_d.st = ST_WAIT;
      end
      ST_WAIT: begin
        // Hold the byte until the engine takes it
        if (link.tx_ready) begin
          r_d.st = ST_DONE;
        end else begin
          r_d.txv = 1'b1;
        end
      end
      ST_DONE: begin
        r_d.idx = r_q.idx + 3'h1;
        r_d.st = ST_IDLE;
        // A request landing mid-indication must not splice its bytes into that packet
        if (r_q.in_cfm) begin
          if (r_q.idx == 3'h3) begin
            r_d.cfm_pend = 1'b0;
            r_d.in_cfm = 1'b0;
          end else begin
            r_d.st = ST_CFM;
          end
        end else if (r_q.idx == 3'(ind_len + 8'h02)) begin
          r_d.seq = r_q.seq + 16'h0001;
        end else if (!r_q.active) begin
          // Stop cut the packet short; the host resyncs on the next type byte
          r_d.st = ST_IDLE;
        end else begin
          r_d.st = ST_IND;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase
  end
  // State register with enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.opc <= 8'h01;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end
endmodule : hpci_top
`default_nettype wire

// file: bench/hpci_top_checker.sv
// Port-level assertions for the packet command interpreter
`default_nettype none
module hpci_top_checker (
  input wire logic i_ref_clk, // System clock
  input wire logic i_resetn, // Sync reset, active low
  input wire logic i_busy, // Start refusal level
  input wire logic o_txd, // Serial to host
  input wire logic o_begin_reading, // Start pulse
  input wire logic o_cancel_reading, // Abort pulse
  input wire logic o_begin_calibrate, // Calibrate pulse
  input wire logic o_session_active // Streaming level
);
  localparam int BIT = hpci_pkg::BIT_CYC;
  int low_q;
  int high_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Line run lengths; int so a long idle never wraps
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      low_q <= 0;
      high_q <= 0;
    end else begin
      low_q <= o_txd ? 0 : low_q + 1;
      high_q <= o_txd ? high_q + 1 : 0;
    end
  end
  // Reset must park the line at idle, so no reset guard here
  chk_idle_in_reset: assert property (disable iff (1'b0) !i_resetn |=> o_txd)
    else $error("serial line not idle after reset");
  chk_low_bit_len: assert property ($rose(o_txd) |->
    low_q != 0 && low_q % BIT == 0) else $error("low run not whole bit times");
  chk_stop_bit_len: assert property ($fell(o_txd) |-> high_q >= BIT)
    else $error("start bit before a full stop bit");
  chk_begin_opens: assert property (o_begin_reading |-> ##[0:1] o_session_active)
    else $error("accepted start did not open session");
  chk_cancel_closes: assert property (o_cancel_reading |->
    ##[0:1] !o_session_active) else $error("abort left session open");
  chk_begin_refused: assert property (o_begin_reading |->
    !$past(o_session_active) && !$past(i_busy))
    else $error("start accepted while busy or active");
  chk_active_cause: assert property ($rose(o_session_active) |->
    o_begin_reading || o_begin_calibrate || $past(o_begin_reading) ||
    $past(o_begin_calibrate)) else $error("session opened without a start");
  chk_pulse_onehot: assert property (
    $onehot0({o_begin_reading, o_cancel_reading, o_begin_calibrate}))
    else $error("two command pulses at once");
  chk_pulse_short: assert property (o_begin_reading |=> !o_begin_reading)
    else $error("start pulse longer than one cycle");
  cov_begin: cover property (o_begin_reading);
  cov_cancel: cover property (o_cancel_reading);
  cov_frame: cover property ($rose(o_txd));
endmodule : hpci_top_checker
bind hpci_top hpci_top_checker i_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_busy(i_busy), .o_txd(o_txd), .o_begin_reading(o_begin_reading),
  .o_cancel_reading(o_cancel_reading), .o_begin_calibrate(o_begin_calibrate),
  .o_session_active(o_session_active));
`default_nettype wire

// file: bench/hpci_host_model.sv
// Host-side serial partner: sends requests, collects device bytes
`default_nettype none
module hpci_host_model (
  input wire logic i_ref_clk, // System clock
  input wire logic i_line_in, // Device serial out
  output logic o_line_out // Serial to device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  int frame_err;
  initial o_line_out = 1'b1;
  // One 8N1 frame, LSB first, line back to idle high after
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_line_out <= f[i];
      repeat (hpci_pkg::BIT_CYC) @(posedge i_ref_clk);
    end
  endtask : send_byte
  // Requests are type and opcode only, no length
  task automatic send_request(input logic [7:0] op);
    send_byte(hpci_pkg::TYPE_REQUEST);
    send_byte(op);
  endtask : send_request
  // Always listening; samples mid-bit to ride out edge jitter
  initial begin : rx_loop
    logic [7:0] b;
    frame_err = 0;
    forever begin
      @(negedge i_line_in);
      repeat (hpci_pkg::HALF_CYC) @(posedge i_ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (hpci_pkg::BIT_CYC) @(posedge i_ref_clk);
        b[i] = i_line_in;
      end
      repeat (hpci_pkg::BIT_CYC) @(posedge i_ref_clk);
      if (i_line_in !== 1'b1) frame_err++;
      rx_q.push_back(b);
    end
  end
endmodule : hpci_host_model
`default_nettype wire

// file: bench/hpci_top_tb.sv
// Self-checking bench for the packet command interpreter
`default_nettype none
module hpci_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_resetn, i_ce, i_rxd, o_txd, i_busy;
  logic i_sample_present, i_reading_done, i_calibrate_done;
  logic [15:0] i_result;
  logic o_begin_reading, o_cancel_reading, o_begin_calibrate, o_session_active;
  int miscompares, checks, begin_cnt, cancel_cnt, cal_cnt;
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  hpci_top i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_rxd(i_rxd),
    .o_txd(o_txd), .i_sample_present(i_sample_present), .i_reading_done(i_reading_done),
    .i_calibrate_done(i_calibrate_done), .i_result(i_result), .i_busy(i_busy),
    .o_begin_reading(o_begin_reading), .o_cancel_reading(o_cancel_reading),
    .o_begin_calibrate(o_begin_calibrate), .o_session_active(o_session_active));
  hpci_host_model i_host (.i_ref_clk(i_ref_clk), .i_line_in(o_txd), .o_line_out(i_rxd));
  // Count command pulses; they last one cycle only
  always @(posedge i_ref_clk) begin
    if (o_begin_reading === 1'b1) begin_cnt++;
    if (o_cancel_reading === 1'b1) cancel_cnt++;
    if (o_begin_calibrate === 1'b1) cal_cnt++;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Bounded wait for n bytes; count checked first so a short packet never passes
  task automatic expect_bytes(input int n, input logic [39:0] exp);
    int t;
    t = 0;
    while (i_host.rx_q.size() < n && t < 60000) begin
      @(posedge i_ref_clk);
      t++;
    end
    check("byte count", 16'(i_host.rx_q.size()), 16'(n));
    for (int i = 0; i < n && i_host.rx_q.size() > 0; i++) begin
      check("byte", {8'h00, i_host.rx_q.pop_front()}, {8'h00, exp[8*(n-1-i) +: 8]});
    end
  endtask : expect_bytes
  // Start request: confirmed OK with opcode echoed, session opens
  task automatic test_start();
    i_host.send_request(8'h00);
    expect_bytes(4, 40'h0043000100);
    check("session", {15'h0000, o_session_active}, 16'h0001);
    check("starts", 16'(begin_cnt), 16'h0001);
    // A reading start must not also kick off a calibration
    check("calibrates", 16'(cal_cnt), 16'h0000);
  endtask : test_start
  // Sample event: unsolicited indication, sequence starts at zero
  task automatic test_indication();
    @(posedge i_ref_clk);
    i_sample_present <= 1'b1;
    @(posedge i_ref_clk);
    i_sample_present <= 1'b0;
    expect_bytes(5, 40'h6903020000);
  endtask : test_indication
  // Stop request: confirmed at once, streaming ends
  task automatic test_stop();
    i_host.send_request(8'h01);
    expect_bytes(4, 40'h0043010100);
    check("session", {15'h0000, o_session_active}, 16'h0000);
    check("aborts", 16'(cancel_cnt), 16'h0001);
    check("framing", 16'(i_host.frame_err), 16'h0000);
  endtask : test_stop
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_busy = 1'b0;
    i_sample_present = 1'b0;
    i_reading_done = 1'b0;
    i_calibrate_done = 1'b0;
    i_result = 16'h0000;
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(posedge i_ref_clk);
    test_start();
    test_indication();
    test_stop();
    tally_and_finish();
  end
  // Seventeen frames at 868 cycles a bit fit well inside this
  initial begin
    repeat (250000) @(posedge i_ref_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : hpci_top_tb
`default_nettype wire
